// ### ipf_pkg.sv
// Package for the instruction prefetch and bus sequencer
package ipf_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int WORD_W = 16;
  // Port width codes
  localparam logic [1:0] PORT_8 = 2'h0;
  localparam logic [1:0] PORT_16 = 2'h1;
  localparam logic [1:0] PORT_32 = 2'h2;
  // Operand size codes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  // Three bytes in one cycle, for a long word that starts at byte offset one or three
  localparam logic [1:0] SZ_TRIPLE = 2'h3;
  localparam logic [1:0] ALIGN_MASK = 2'h3;
  localparam logic [ADDR_W-1:0] LONG_STEP = 32'h0000_0004;
  localparam logic [ADDR_W-1:0] WORD_STEP = 32'h0000_0002;
  localparam logic [ADDR_W-1:0] LW_BASE_MASK = 32'hffff_fffc;

  typedef enum logic [1:0] {IPF_IDLE, IPF_FETCH, IPF_OPER} ipf_bus_state_t;

  // Request from the execution sequencer
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] size;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ipf_op_req_t;

  // External bus cycle
  typedef struct packed {
    logic start;
    logic write;
    logic fetch;
    logic [1:0] size;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ipf_bus_req_t;
endpackage

// ### ipf_sequencer.sv
// Instruction prefetch and bus sequencing front end
// Contract
// - The cache holds instruction words only and never serves operand reads or writes.
// - A fetch that hits in the cache returns its word the cycle after the lookup, except while a fetch read runs.
// - A cache miss starts an external read while execution of earlier instructions continues.
// - External fetches are long-word reads and the second word is kept so the next fetch needs no bus cycle.
// - An odd-word fetch also reads the even word, together on a 32-bit port, even word first on narrow ports.
// - An even-word fetch reads both words of the long word and keeps the odd word for the next fetch.
// - Operands that do not fit the port in one cycle are split automatically; a 32-bit port splits only at long-word boundaries.
// - The bus controller runs operand cycles while the sequencer works on addresses or condition codes.
// - A sequencer request made while a cycle runs is queued and issued when the current cycle ends, or after the read for a pending cache miss.
// - A status register write can finish before an earlier queued write completes, so software adds a no-op.
module ipf_sequencer
  import ipf_pkg::*;
#(
  parameter int ADDR_W_P = ADDR_W
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Configuration
  input wire logic [1:0] PORT_WIDTH,
  // Instruction fetch from sequencer
  input wire logic FETCH_REQ,
  input wire logic FETCH_BRANCH,
  input wire logic [ADDR_W-1:0] FETCH_ADDR,
  output logic FETCH_VALID,
  output logic [WORD_W-1:0] FETCH_WORD,
  // Instruction cache lookup
  output logic CACHE_LOOKUP,
  output logic [ADDR_W-1:0] CACHE_ADDR,
  input wire logic CACHE_HIT,
  input wire logic [WORD_W-1:0] CACHE_WORD,
  // Operand request from sequencer
  input wire ipf_pkg::ipf_op_req_t OP_REQ,
  output logic OP_ACCEPT,
  output logic OP_DONE,
  output logic [DATA_W-1:0] OP_RDATA,
  output logic OP_PENDING,
  // External bus
  output ipf_pkg::ipf_bus_req_t BUS_REQ,
  input wire logic BUS_ACK,
  input wire logic [DATA_W-1:0] BUS_RDATA
);
  import ipf_pkg::*;

  typedef struct packed {
    ipf_bus_state_t st;
    logic lw_valid;
    logic [ADDR_W-1:0] lw_addr;
    logic [WORD_W-1:0] lw_even;
    logic [WORD_W-1:0] lw_odd;
    logic half_done;
    logic [ADDR_W-1:0] f_addr;
    logic q_valid;
    logic m_pend;
    logic pend;
    ipf_op_req_t q;
    logic [ADDR_W-1:0] o_addr;
    logic [2:0] o_left;
    logic [DATA_W-1:0] o_acc;
    ipf_bus_req_t bus;
    logic f_valid;
    logic [WORD_W-1:0] f_word;
    logic c_lookup;
    logic [ADDR_W-1:0] c_addr;
    logic o_accept;
    logic o_done;
    logic [DATA_W-1:0] o_rdata;
  } ipf_state_t;

  ipf_state_t s_reg, s_next;
  logic in_buf;
  logic [ADDR_W-1:0] fbase;
  logic [2:0] nbytes;
  logic [2:0] chunk;
  logic [1:0] lane;
  logic miss_now;
  logic [2:0] first;
  logic [2:0] nchunk;
  logic [ADDR_W-1:0] o_addr_nx;
  logic [DATA_W-1:0] acc_nx;

  // Bytes a single cycle can move from the current address
  function automatic logic [2:0] chunk_len(input logic [1:0] pw, input logic [1:0] off, input logic [2:0] left);
    logic [2:0] room;
    room = 3'h4 - {1'b0, off};
    if (pw == PORT_8) room = 3'h1;
    else if (pw == PORT_16) room = 3'h2 - {2'h0, off[0]};
    chunk_len = (left < room) ? left : room;
  endfunction

  // Size code names what one cycle really moves, so no cycle crosses a long word
  function automatic logic [1:0] size_code(input logic [2:0] n);
    size_code = SZ_LONG;
    if (n == 3'h1) size_code = SZ_BYTE;
    else if (n == 3'h2) size_code = SZ_WORD;
    else if (n == 3'h3) size_code = SZ_TRIPLE;
  endfunction

  always_comb begin
    s_next = s_reg;
    s_next.f_valid = 1'b0;
    s_next.o_accept = 1'b0;
    s_next.o_done = 1'b0;
    s_next.c_lookup = 1'b0;
    s_next.bus.start = 1'b0;
    fbase = FETCH_ADDR & LW_BASE_MASK;
    in_buf = s_reg.lw_valid && (s_reg.lw_addr == fbase);
    nbytes = 3'h1;
    if (s_reg.q.size == SZ_WORD) nbytes = 3'h2;
    else if (s_reg.q.size == SZ_LONG) nbytes = 3'h4;
    lane = s_reg.o_addr[1:0] & ALIGN_MASK;
    chunk = chunk_len(PORT_WIDTH, lane, s_reg.o_left);
    first = chunk_len(PORT_WIDTH, s_reg.q.addr[1:0], nbytes);
    o_addr_nx = s_reg.o_addr + {29'h0, chunk};
    nchunk = chunk_len(PORT_WIDTH, o_addr_nx[1:0], s_reg.o_left - chunk);
    // Addressed bytes arrive in the top lanes; shift them in behind earlier beats
    acc_nx = (s_reg.o_acc << {chunk, 3'h0}) | (BUS_RDATA >> (6'(DATA_W) - {chunk, 3'h0}));
    miss_now = s_reg.c_lookup && !CACHE_HIT
               && !(s_reg.lw_valid && s_reg.lw_addr == (s_reg.c_addr & LW_BASE_MASK));
    // A miss seen while the bus is busy waits here instead of being lost
    if (miss_now) s_next.m_pend = 1'b1;
    if (FETCH_BRANCH) s_next.lw_valid = 1'b0;
    // Cache only answers fetches; operands never look it up
    if (FETCH_REQ) begin
      s_next.c_lookup = 1'b1;
      s_next.c_addr = FETCH_ADDR;
    end
    // Hit delivered straight away
    if (s_reg.c_lookup && CACHE_HIT && s_reg.st != IPF_FETCH) begin
      s_next.f_valid = 1'b1;
      s_next.f_word = CACHE_WORD;
    end
    // Held second word serves the next fetch without a bus cycle
    if (FETCH_REQ && !FETCH_BRANCH && in_buf) begin
      s_next.f_valid = 1'b1;
      s_next.f_word = FETCH_ADDR[1] ? s_reg.lw_odd : s_reg.lw_even;
      s_next.c_lookup = 1'b0;
    end
    // Queue one operand request; accepted while the bus is busy
    if (OP_REQ.valid && !s_reg.q_valid) begin
      s_next.q_valid = 1'b1;
      s_next.q = OP_REQ;
      s_next.o_accept = 1'b1;
    end
    unique case (s_reg.st)
      IPF_IDLE: begin
        // Misses start a long-word read; fetches have priority over operands
        if (miss_now || s_reg.m_pend) begin
          s_next.st = IPF_FETCH;
          s_next.m_pend = 1'b0;
          s_next.f_addr = s_reg.c_addr;
          s_next.half_done = 1'b0;
          s_next.bus = '{start: 1'b1, write: 1'b0, fetch: 1'b1, size: SZ_LONG,
                         addr: s_reg.c_addr & LW_BASE_MASK, wdata: '0};
        end else if (s_reg.q_valid) begin
          s_next.st = IPF_OPER;
          s_next.q_valid = 1'b0;
          s_next.o_addr = s_reg.q.addr;
          s_next.o_left = nbytes;
          s_next.o_acc = '0;
          s_next.bus.write = s_reg.q.write;
          s_next.bus.fetch = 1'b0;
          s_next.bus.addr = s_reg.q.addr;
          s_next.bus.wdata = s_reg.q.wdata;
          s_next.bus.start = 1'b1;
          s_next.bus.size = size_code(first);
        end
      end
      IPF_FETCH: begin
        if (BUS_ACK) begin
          if (PORT_WIDTH == PORT_32) begin
            // Both words of the long word arrive together
            s_next.lw_even = BUS_RDATA[DATA_W-1:WORD_W];
            s_next.lw_odd = BUS_RDATA[WORD_W-1:0];
            s_next.half_done = 1'b1;
          end else if (!s_reg.half_done) begin
            s_next.lw_even = BUS_RDATA[DATA_W-1:WORD_W];
            s_next.half_done = 1'b1;
            s_next.bus.start = 1'b1;
            s_next.bus.size = SZ_WORD;
            s_next.bus.addr = (s_reg.f_addr & LW_BASE_MASK) + WORD_STEP;
          end else begin
            s_next.lw_odd = BUS_RDATA[DATA_W-1:WORD_W];
          end
          // A narrow port returns one word per cycle; 8-bit dynamic sizing left to bus logic
          if (PORT_WIDTH == PORT_32 || s_reg.half_done) begin
            s_next.st = IPF_IDLE;
            s_next.lw_valid = !FETCH_BRANCH;
            s_next.lw_addr = s_reg.f_addr & LW_BASE_MASK;
            s_next.f_valid = 1'b1;
            s_next.f_word = s_reg.f_addr[1] ? BUS_RDATA[WORD_W-1:0]
                          : (PORT_WIDTH == PORT_32 ? BUS_RDATA[DATA_W-1:WORD_W] : s_reg.lw_even);
            if (s_reg.f_addr[1] && PORT_WIDTH != PORT_32) s_next.f_word = BUS_RDATA[DATA_W-1:WORD_W];
          end
        end
      end
      IPF_OPER: begin
        if (BUS_ACK) begin
          // Split into more cycles until every byte has moved
          if (!s_reg.bus.write) s_next.o_acc = acc_nx;
          s_next.o_left = s_reg.o_left - chunk;
          s_next.o_addr = o_addr_nx;
          if (s_reg.o_left == chunk) begin
            s_next.st = IPF_IDLE;
            s_next.o_done = 1'b1;
            s_next.o_rdata = s_reg.bus.write ? '0 : acc_nx;
          end else begin
            s_next.bus.start = 1'b1;
            s_next.bus.addr = o_addr_nx;
            s_next.bus.size = size_code(nchunk);
          end
        end
      end
      default: s_next.st = IPF_IDLE;
    endcase
    s_next.pend = s_next.q_valid || s_next.st == IPF_OPER;
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) s_reg <= '0;
    else s_reg <= s_next;
  end

  assign FETCH_VALID = s_reg.f_valid;
  assign FETCH_WORD = s_reg.f_word;
  assign CACHE_LOOKUP = s_reg.c_lookup;
  assign CACHE_ADDR = s_reg.c_addr;
  assign OP_ACCEPT = s_reg.o_accept;
  assign OP_DONE = s_reg.o_done;
  assign OP_RDATA = s_reg.o_rdata;
  assign OP_PENDING = s_reg.pend;
  assign BUS_REQ = s_reg.bus;
endmodule // ipf_sequencer

// ### ipf_sequencer_asserts.sv
// Port-level assertions for the prefetch and bus sequencer
module ipf_sequencer_asserts
  import ipf_pkg::*;
(
  // Clock, reset, config
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic [1:0] PORT_WIDTH,
  // Fetch and cache
  input wire logic FETCH_VALID,
  input wire logic [WORD_W-1:0] FETCH_WORD,
  input wire logic CACHE_LOOKUP,
  input wire logic CACHE_HIT,
  input wire logic [WORD_W-1:0] CACHE_WORD,
  // Operands and bus
  input wire ipf_pkg::ipf_op_req_t OP_REQ,
  input wire logic OP_ACCEPT,
  input wire logic OP_DONE,
  input wire logic OP_PENDING,
  input wire ipf_pkg::ipf_bus_req_t BUS_REQ,
  input wire logic BUS_ACK
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);
  a_hit_word: assert property (CACHE_LOOKUP && CACHE_HIT |=> FETCH_VALID && FETCH_WORD == $past(CACHE_WORD))
    else $error("hit word late or wrong");
  a_miss_read: assert property (CACHE_LOOKUP && !CACHE_HIT |-> ##[1:40] BUS_REQ.start && BUS_REQ.fetch)
    else $error("miss started no read");
  a_fetch_long: assert property (BUS_REQ.start && BUS_REQ.fetch && PORT_WIDTH == PORT_32 |->
    !BUS_REQ.write && BUS_REQ.size == SZ_LONG && BUS_REQ.addr[1:0] == 2'h0) else $error("fetch not long word");
  a_op_span: assert property (BUS_REQ.start && !BUS_REQ.fetch |->
    {1'b0, BUS_REQ.addr[1:0]} + ((BUS_REQ.size == SZ_TRIPLE) ? 3'h3 : (3'h1 << BUS_REQ.size)) <= 3'h4)
    else $error("operand cycle crosses long word");
  a_start_pulse: assert property (BUS_REQ.start |=> !BUS_REQ.start)
    else $error("bus start not a pulse");
  a_accept_cause: assert property (OP_ACCEPT |-> $past(OP_REQ.valid))
    else $error("accept without request");
  a_pending_ends: assert property (OP_PENDING |-> ##[0:400] !OP_PENDING)
    else $error("queued operand never issued");
  a_done_ack: assert property (OP_DONE |-> $past(BUS_ACK))
    else $error("operand done without bus cycle");
endmodule // ipf_sequencer_asserts

// ### ipf_mem_model.sv
// Behavioural external memory on the processor bus
module ipf_mem_model
  import ipf_pkg::*;
(
  // Clock, reset, wait states
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] wait_cyc,
  // Bus
  input wire ipf_pkg::ipf_bus_req_t req,
  output logic ack,
  output logic [DATA_W-1:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  logic [3:0] cnt;
  logic [ADDR_W-1:0] a;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {busy, ack, cnt, a, rdata} <= '0;
    end else begin
      ack <= 1'b0;
      // Released lanes toggle so stale data never looks valid
      rdata <= ~rdata;
      if (req.start) begin
        busy <= 1'b1;
        cnt <= wait_cyc;
        a <= req.addr;
      end else if (busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        ack <= 1'b1;
        // Addressed byte always leads in the top lane, as a narrow port sees it
        rdata <= ({a[16:2], 1'b0, a[16:2], 1'b1} ^ 32'h3c96_3c96) << {a[1:0], 3'h0};
      end
    end
  end
endmodule // ipf_mem_model

// ### ipf_sequencer_test.sv
// Self-checking bench for the prefetch and bus sequencer
module ipf_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ipf_pkg::*;
  logic SYS_CLK = 1'b0, RESET = 1'b1, FETCH_REQ = 1'b0, FETCH_BRANCH = 1'b0, hit_en = 1'b0;
  logic [1:0] PORT_WIDTH = PORT_32;
  logic [3:0] wait_cyc = 4'h0;
  logic [ADDR_W-1:0] FETCH_ADDR = '0, CACHE_ADDR;
  ipf_op_req_t OP_REQ = '0;
  ipf_bus_req_t BUS_REQ;
  logic FETCH_VALID, CACHE_LOOKUP, OP_ACCEPT, OP_DONE, OP_PENDING, BUS_ACK;
  logic [WORD_W-1:0] FETCH_WORD;
  logic [DATA_W-1:0] OP_RDATA, BUS_RDATA;
  int failures = 0, checks_done = 0, starts = 0;
  logic [31:0] lfsr = 32'h0001_6d1e;
  function automatic logic [15:0] wd(logic [31:0] x);
    return {x[16:2], x[1]} ^ 16'h3c96;
  endfunction
  function automatic logic [31:0] exp_rd(logic [31:0] x, logic [1:0] s);
    logic [31:0] r, y, l;
    r = '0;
    for (int k = 0; k < (1 << s); k++) begin
      y = x + k;
      l = {wd({y[31:2], 2'h0}), wd({y[31:2], 2'h2})};
      r = {r[23:0], l[31 - 8 * y[1:0] -: 8]};
    end
    return r;
  endfunction
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  wire logic CACHE_HIT = CACHE_LOOKUP & hit_en;
  wire logic [WORD_W-1:0] CACHE_WORD = wd(CACHE_ADDR);
  ipf_sequencer u_dut (.SYS_CLK, .RESET, .PORT_WIDTH, .FETCH_REQ, .FETCH_BRANCH, .FETCH_ADDR, .FETCH_VALID,
    .FETCH_WORD, .CACHE_LOOKUP, .CACHE_ADDR, .CACHE_HIT, .CACHE_WORD, .OP_REQ, .OP_ACCEPT, .OP_DONE,
    .OP_RDATA, .OP_PENDING, .BUS_REQ, .BUS_ACK, .BUS_RDATA);
  ipf_mem_model u_mem (.clk(SYS_CLK), .rst(RESET), .wait_cyc, .req(BUS_REQ), .ack(BUS_ACK), .rdata(BUS_RDATA));
  initial forever #4 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) if (BUS_REQ.start) starts <= starts + 1;
  task automatic stop_test();
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic hold(ref logic s, input logic v);
    // Sample mid-cycle, where registered outputs have settled
    for (int i = 0; i < 200; i++) begin
      @(negedge SYS_CLK);
      if (s === v) break;
    end
    if (s !== v) begin
      failures++;
      stop_test();
    end
  endtask
  task automatic fetch(input logic [31:0] a, input logic br, input int nb);
    int s0;
    s0 = starts;
    @(posedge SYS_CLK);
    {FETCH_REQ, FETCH_BRANCH, FETCH_ADDR} <= {1'b1, br, a};
    @(posedge SYS_CLK);
    {FETCH_REQ, FETCH_BRANCH} <= 2'h0;
    hold(FETCH_VALID, 1'b1);
    cmp("fetch word", 32'(wd(a)), 32'(FETCH_WORD));
    if (nb >= 0) cmp("fetch cycles", nb, starts - s0);
  endtask
  task automatic op(input logic w, input logic [1:0] sz, input logic [31:0] a);
    @(posedge SYS_CLK);
    OP_REQ <= {1'b1, w, sz, a, rnd()};
    hold(OP_ACCEPT, 1'b1);
    @(posedge SYS_CLK);
    OP_REQ.valid <= 1'b0;
  endtask
  initial begin
    int s0;
    logic [1:0] sz;
    logic [31:0] a;
    logic w;
    repeat (6) @(posedge SYS_CLK);
    RESET <= 1'b0;
    fetch(32'h0000_0100, 1'b1, 1);
    fetch(32'h0000_0102, 1'b0, 0);
    fetch(32'h0000_0300, 1'b1, 1);
    fetch(32'h0000_0302, 1'b1, 1);
    fetch(32'h0000_0206, 1'b1, 1);
    // Slow memory so the second operand must wait
    wait_cyc <= 4'h6;
    s0 = starts;
    op(1'b1, SZ_LONG, 32'h0000_0802);
    op(1'b0, SZ_WORD, 32'h0000_0903);
    cmp("queued", 1, 32'(OP_PENDING));
    hit_en <= 1'b1;
    fetch(32'h0000_0500, 1'b1, -1);
    hold(OP_PENDING, 1'b0);
    cmp("queued cycles", 4, starts - s0);
    hit_en <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      a = rnd();
      sz = i < 3 ? SZ_LONG : 2'(rnd() % 3);
      if (i < 3) a[1:0] = 2'h0;
      wait_cyc <= 4'(rnd() & 3);
      s0 = starts;
      w = i >= 3 && rnd() % 2 == 1;
      op(w, sz, a);
      hold(OP_DONE, 1'b1);
      cmp("op cycles", (int'(a[1:0]) + (1 << sz) - 1) / 4 + 1, starts - s0);
      if (!w) cmp("op rdata", exp_rd(a, sz), OP_RDATA);
    end
    for (int p = 0; p < 2; p++) begin
      @(posedge SYS_CLK);
      RESET <= 1'b1;
      PORT_WIDTH <= p ? PORT_8 : PORT_16;
      repeat (2) @(posedge SYS_CLK);
      RESET <= 1'b0;
      fetch(32'h0000_0206, 1'b1, 2);
    end
    stop_test();
  end
endmodule // ipf_sequencer_test
bind ipf_sequencer ipf_sequencer_asserts u_chk (.SYS_CLK, .RESET, .PORT_WIDTH, .FETCH_VALID, .FETCH_WORD,
  .CACHE_LOOKUP, .CACHE_HIT, .CACHE_WORD, .OP_REQ, .OP_ACCEPT, .OP_DONE, .OP_PENDING, .BUS_REQ, .BUS_ACK);
